// >>> hdl/acsr_pkg.sv
/*
 * Constants, types and decode layout for the channel select and result
 * readout block. Assumes one 250 MHz system clock and a synchronous reset.
 */
package acsr_pkg;

	// Register select codes carried in the command byte
	localparam logic [2:0] RSEL_STATUS = 3'h0;
	localparam logic [2:0] RSEL_MODE = 3'h1;
	localparam logic [2:0] RSEL_CONFIG = 3'h2;
	localparam logic [2:0] RSEL_RESULT = 3'h3;
	localparam logic [2:0] RSEL_IDENT = 3'h4;
	localparam logic [2:0] RSEL_GPO = 3'h5;
	localparam logic [2:0] RSEL_OFFSET = 3'h6;
	localparam logic [2:0] RSEL_FULLSCALE = 3'h7;

	// Command byte field positions
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_READ_BIT = 6;
	localparam int CMD_RSEL_LSB = 3;

	// Frame lengths in serial clock periods
	localparam logic [5:0] LEN_CMD = 6'h08;
	localparam logic [5:0] LEN_BYTE = 6'h08;
	localparam logic [5:0] LEN_WORD = 6'h18;
	localparam logic [5:0] LEN_WORD_STATUS = 6'h20;

	// Values after reset
	localparam logic [23:0] RESULT_RESET = 24'h000000;
	localparam logic [3:0] CODE_RESET = 4'h0;

	// Status byte layout
	localparam int STAT_PEND_BIT = 7;

	// Input selector encoding: 0..7 are AIN1..AIN8
	localparam logic [3:0] IN_AIN1 = 4'h0;
	localparam logic [3:0] IN_AIN2 = 4'h1;
	localparam logic [3:0] IN_COMMON = 4'h8;
	localparam logic [3:0] IN_TEMP = 4'h9;

	// Channel codes for the two special selections
	localparam logic [3:0] CODE_TEMP = 4'h8;
	localparam logic [3:0] CODE_SHORT = 4'h9;
	localparam logic [2:0] CAL_SHARED = 3'h4;

	typedef enum logic [1:0] {
		ST_CMD,
		ST_READ,
		ST_WRITE
	} acsr_state_e;

	// Decoded channel selection
	typedef struct packed {
		logic valid;
		logic [3:0] pos;
		logic [3:0] neg;
		logic [3:0] code;
		logic cal_valid;
		logic [2:0] cal_pair;
	} acsr_chan_s;

	// Channel enable group from the configuration logic
	typedef struct packed {
		logic [7:0] chan;
		logic temp;
		logic short_in;
		logic single_ended;
	} acsr_enable_s;

endpackage : acsr_pkg

// >>> hdl/acsr_top.sv
/*
 * Channel selection decode plus result, status and identity readout over
 * the four-wire serial port. Assumes the serial clock idles high, data in
 * is taken on its rising edge and data out changes on its falling edge,
 * and that the clock is far slower than i_clk (sampled, not a domain).
 */
// Function
// R01: Differential mode: enable bits pick four pairs, codes 0000-0111, cal pairs 0-3.
// R02: Single-ended mode: bits pick AIN1-8 against common, bits 4-7 share pair 4.
// R03: Temp enable gives code 1000 no pair; short gives code 1001, pair 0.
// R04: Select code 011 reads 24-bit read-only result, reset value zero.
// R05: Finished result read sets pending on pin and status until next result.
// R06: Append enable adds the status byte to each result read out.
// R07: Low four status bits hold the channel code of the appended result.
// R08: Select code 100 reads read-only identity; writes to it do nothing.
// R09: Appended read shifts 24 result bits then 8 status bits, 32 total.
`timescale 1ns/1ps
module acsr_top
	import acsr_pkg::*;
#(
	parameter logic [7:0] IDENT_VALUE = 8'h5a // Arbitrary identity value
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Serial port pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	output logic o_dout,
	output logic o_conv_pending,
	// Configuration levels
	input wire acsr_enable_s i_enable,
	input wire logic i_append_status_enable,
	// Converter core
	input wire logic i_result_valid,
	input wire logic [23:0] i_result_data,
	// Decoded channel to the analog front end
	output acsr_chan_s o_chan
);

	// Maps the enable group to inputs, channel code and calibration pair
	function automatic acsr_chan_s chan_decode(input acsr_enable_s en);
		acsr_chan_s c;
		c = '0;
		if (|en.chan) begin
			for (int i = 7; i >= 0; i--) begin
				if (en.chan[i]) begin
					c.valid = 1'b1;
					c.code = 4'(i);
					c.cal_valid = 1'b1;
					if (en.single_ended) begin
						c.pos = 4'(i); // [R02]
						c.neg = IN_COMMON;
						c.cal_pair = (i > 3) ? CAL_SHARED : 3'(i); // [R02]
					end else begin
						c.pos = 4'((i % 4) * 2); // [R01]
						c.neg = 4'((i % 4) * 2 + 1);
						c.cal_pair = 3'(i % 4); // [R01]
					end
				end
			end
		end else if (en.temp) begin
			c.valid = 1'b1;
			c.pos = IN_TEMP; // [R03]
			c.neg = IN_TEMP;
			c.code = CODE_TEMP;
		end else if (en.short_in) begin
			c.valid = 1'b1;
			c.pos = en.single_ended ? IN_COMMON : IN_AIN2; // [R03]
			c.neg = en.single_ended ? IN_COMMON : IN_AIN2;
			c.code = CODE_SHORT;
			c.cal_valid = 1'b1;
			c.cal_pair = 3'h0;
		end
		return c;
	endfunction : chan_decode

	// Frame length of the data phase for each register select code
	function automatic logic [5:0] data_len(input logic [2:0] rsel, input logic append);
		logic [5:0] n;
		n = LEN_WORD;
		case (rsel)
			RSEL_STATUS, RSEL_IDENT, RSEL_GPO: n = LEN_BYTE;
			RSEL_RESULT: n = append ? LEN_WORD_STATUS : LEN_WORD; // [R06]
			default: n = LEN_WORD;
		endcase
		return n;
	endfunction : data_len

	typedef struct packed {
		logic [1:0] sclk_sync;
		logic [1:0] cs_sync;
		logic [1:0] din_sync;
		logic sclk_last;
		acsr_state_e state;
		logic [5:0] bits_left;
		logic [7:0] cmd;
		logic [31:0] shift;
		logic [2:0] rsel;
		logic [23:0] result;
		logic [3:0] result_code;
		logic pending;
		logic dout;
		acsr_chan_s chan;
	} acsr_state_s;

	acsr_state_s st_r;
	acsr_state_s st_nxt;

	logic sclk_rise;
	logic sclk_fall;
	logic selected;
	logic [7:0] status_byte;
	logic [7:0] cmd_full;
	logic read_done;

	// Edges come from the second sync stage and its delayed copy only
	assign sclk_rise = st_r.sclk_sync[1] & ~st_r.sclk_last;
	assign sclk_fall = ~st_r.sclk_sync[1] & st_r.sclk_last;
	assign selected = ~st_r.cs_sync[1];
	assign status_byte = {st_r.pending, 3'h0, st_r.result_code}; // [R07]
	assign cmd_full = {st_r.cmd[6:0], st_r.din_sync[1]};
	assign read_done = selected && sclk_rise && st_r.state == ST_READ
		&& st_r.bits_left == 6'h01 && st_r.rsel == RSEL_RESULT;

	// Next-state logic for the whole block
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_sync = {st_r.sclk_sync[0], i_sclk};
		st_nxt.cs_sync = {st_r.cs_sync[0], i_cs_n};
		st_nxt.din_sync = {st_r.din_sync[0], i_din};
		st_nxt.sclk_last = st_r.sclk_sync[1];
		st_nxt.chan = chan_decode(i_enable);

		if (!selected) begin
			// Deselect aborts any frame; the host restarts with a command
			st_nxt.state = ST_CMD;
			st_nxt.bits_left = LEN_CMD;
		end else begin
			case (st_r.state)
				ST_CMD: begin
					if (sclk_rise) begin
						st_nxt.cmd = cmd_full;
						st_nxt.bits_left = st_r.bits_left - 6'h01;
						if (st_r.bits_left == 6'h01) begin
							st_nxt.rsel = cmd_full[CMD_RSEL_LSB +: 3];
							st_nxt.bits_left = data_len(cmd_full[CMD_RSEL_LSB +: 3],
								i_append_status_enable);
							if (cmd_full[CMD_WEN_BIT]) begin
								// Write-enable bit high: not a command, wait again
								st_nxt.bits_left = LEN_CMD;
							end else if (cmd_full[CMD_READ_BIT]) begin
								st_nxt.state = ST_READ;
								case (cmd_full[CMD_RSEL_LSB +: 3])
									RSEL_STATUS: st_nxt.shift = {status_byte, 24'h000000};
									RSEL_RESULT: st_nxt.shift = {st_r.result, status_byte}; // [R04] [R09]
									RSEL_IDENT: st_nxt.shift = {IDENT_VALUE, 24'h000000}; // [R08]
									default: st_nxt.shift = 32'h00000000;
								endcase
							end else begin
								st_nxt.state = ST_WRITE;
							end
						end
					end
				end
				ST_READ: begin
					if (sclk_fall) begin
						st_nxt.dout = st_r.shift[31];
						st_nxt.shift = {st_r.shift[30:0], 1'b0};
					end
					if (sclk_rise) begin
						st_nxt.bits_left = st_r.bits_left - 6'h01;
						if (st_r.bits_left == 6'h01) begin
							st_nxt.state = ST_CMD;
							st_nxt.bits_left = LEN_CMD;
						end
					end
				end
				ST_WRITE: begin
					// Data is counted and dropped; identity and result ignore writes
					if (sclk_rise) begin
						st_nxt.bits_left = st_r.bits_left - 6'h01; // [R08]
						if (st_r.bits_left == 6'h01) begin
							st_nxt.state = ST_CMD;
							st_nxt.bits_left = LEN_CMD;
						end
					end
				end
				default: begin
					st_nxt.state = ST_CMD;
					st_nxt.bits_left = LEN_CMD;
				end
			endcase
		end

		// Pending goes high when the result read finishes
		if (read_done) begin
			st_nxt.pending = 1'b1; // [R05]
		end
		// A fresh result wins over a read ending in the same cycle
		if (i_result_valid) begin
			st_nxt.result = i_result_data; // [R04]
			st_nxt.result_code = st_r.chan.code; // [R07]
			st_nxt.pending = 1'b0; // [R05]
		end
	end

	// State register; reset values are constants only
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_r <= '0;
			st_r.sclk_sync <= 2'h3;
			st_r.cs_sync <= 2'h3;
			st_r.sclk_last <= 1'b1;
			st_r.state <= ST_CMD;
			st_r.bits_left <= LEN_CMD;
			st_r.result <= RESULT_RESET;
			st_r.result_code <= CODE_RESET;
			st_r.pending <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign o_dout = st_r.dout;
	assign o_conv_pending = st_r.pending; // [R05]
	assign o_chan = st_r.chan;

endmodule : acsr_top

// >>> bench/acsr_monitor.sv
/*
 * Port checker for the channel decode and result readout block.
 * Assumes it is bound to acsr_top and sees only its ports.
 */
`timescale 1ns/1ps
module acsr_monitor
	import acsr_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Watched ports
	input wire acsr_enable_s i_enable,
	input wire logic i_result_valid,
	input wire logic o_dout,
	input wire logic o_conv_pending,
	input wire acsr_chan_s o_chan
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	// Reset must be checked while it is high, so it opts out of the disable
	a_reset_vals: assert property (disable iff (1'b0) i_sys_rst |=>
		o_conv_pending && !o_dout && o_chan == '0) else $error("bad reset values");
	// Only a new result clears pending
	a_pend_clear: assert property (i_result_valid |=> !o_conv_pending)
		else $error("pending not cleared");
	a_pend_hold: assert property (o_conv_pending && !i_result_valid |=> o_conv_pending)
		else $error("pending dropped");
	// Decode follows the enables one clock later
	a_chan_valid: assert property (|{i_enable.chan, i_enable.temp, i_enable.short_in}
		|=> o_chan.valid) else $error("no channel chosen");
	a_temp_sel: assert property (i_enable.chan == '0 && i_enable.temp |=>
		o_chan.code == CODE_TEMP && !o_chan.cal_valid) else $error("bad temp decode");
	a_short_sel: assert property (i_enable.chan == '0 && !i_enable.temp &&
		i_enable.short_in |=> o_chan.code == CODE_SHORT && o_chan.cal_pair == 3'h0
		&& o_chan.pos == o_chan.neg) else $error("bad short decode");
	a_single_neg: assert property (i_enable.single_ended && |i_enable.chan |=>
		o_chan.neg == IN_COMMON && o_chan.cal_pair ==
		(o_chan.code[2] ? CAL_SHARED : o_chan.code[2:0])) else $error("bad single decode");
	a_diff_pair: assert property (!i_enable.single_ended && |i_enable.chan |=>
		o_chan.neg == o_chan.pos + 4'h1 && o_chan.cal_pair == {1'b0, o_chan.code[1:0]})
		else $error("bad pair decode");
endmodule : acsr_monitor

bind acsr_top acsr_monitor u_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_enable(i_enable), .i_result_valid(i_result_valid), .o_dout(o_dout),
	.o_conv_pending(o_conv_pending), .o_chan(o_chan));

// >>> bench/acsr_host.sv
/*
 * Host model of the serial port: frames a command and clocks data.
 * Assumes the clock idles high and data out settles well before a rise.
 */
`timescale 1ns/1ps
module acsr_host (
	// Serial port, host side
	output logic o_sclk,
	output logic o_cs_n,
	input wire logic i_dout,
	output logic o_din
);
	// Idle: clock high, deselected
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end

	// Command byte then n bits, MSB first; clock stands still outside frames
	task automatic xfer(input logic [7:0] cmd, input int n, output logic [31:0] q);
		q = '0;
		o_cs_n = 1'b0;
		#80;
		for (int i = 0; i < 8 + n; i++) begin
			o_sclk = 1'b0;
			o_din = (i < 8) ? cmd[7 - i] : ~o_din; // Toggle so stale data never matches
			#80;
			o_sclk = 1'b1;
			if (i >= 8) q = {q[30:0], i_dout};
			#80;
		end
		o_cs_n = 1'b1;
		o_din = ~o_din;
		#160;
	endtask : xfer
endmodule : acsr_host

// >>> bench/test_adc_channel_select_result_readout.sv
/*
 * Self-checking bench: decode sweep, result and identity reads.
 * Assumes acsr_top, the host model and the bound checker.
 */
`timescale 1ns/1ps
module test_adc_channel_select_result_readout
	import acsr_pkg::*;
;
	localparam logic [7:0] IDV = 8'h3c; // Arbitrary identity value
	logic clk, rst, rv, app, sclk, cs_n, din, dout, pend;
	logic [23:0] rd;
	logic [31:0] q;
	logic [15:0] r;
	acsr_enable_s en;
	acsr_chan_s chan, m;
	int miscompares, checks_done;

	// Clock
	always #2 clk = ~clk;

	acsr_top #(.IDENT_VALUE(IDV)) u_dut (.i_clk(clk), .i_sys_rst(rst), .i_sclk(sclk),
		.i_cs_n(cs_n), .i_din(din), .o_dout(dout), .o_conv_pending(pend), .i_enable(en),
		.i_append_status_enable(app), .i_result_valid(rv), .i_result_data(rd), .o_chan(chan));
	acsr_host u_host (.o_sclk(sclk), .o_cs_n(cs_n), .i_dout(dout), .o_din(din));

	// Reference decode; lowest channel bit wins
	function automatic acsr_chan_s dec(acsr_enable_s e);
		acsr_chan_s c;
		logic s;
		c = '0;
		s = e.single_ended;
		for (int i = 7; i >= 0; i--) begin
			if (e.chan[i]) c = '{1'b1, 4'(s ? i : 2 * (i % 4)), 4'(s ? 8 : 2 * (i % 4) + 1),
				4'(i), 1'b1, 3'(s ? (i < 4 ? i : 4) : i % 4)};
		end
		if (e.chan == '0 && e.temp) c = '{1'b1, 4'h9, 4'h9, 4'h8, 1'b0, 3'h0};
		else if (e.chan == '0 && e.short_in) c = '{1'b1, s ? 4'h8 : 4'h1, s ? 4'h8 : 4'h1,
			4'h9, 1'b1, 3'h0};
		return c;
	endfunction : dec

	function automatic logic [15:0] lfsr(logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report;
		if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		{clk, rv, app, rd, en} = '0;
		rst = 1'b1;
		r = 16'h103e;
		tick(8);
		rst = 1'b0;
		tick(4);
		chk(pend, 1);
		u_host.xfer(8'h58, 24, q);
		chk(q, 0);
		// One-hot enables, both modes, then random mixes
		for (int k = 0; k < 40; k++) begin
			r = lfsr(r);
			en = (k < 24) ? acsr_enable_s'((11'h2 << (k >> 1)) | 11'(k % 2)) : acsr_enable_s'(r[10:0]);
			tick(2);
			chk(chan, dec(en));
		end
		// Results with and without status append
		for (int k = 0; k < 4; k++) begin
			r = lfsr(r);
			en = '{chan: 8'h1 << r[2:0], temp: 1'b0, short_in: 1'b0, single_ended: r[3]};
			app = k[0];
			rd = {r[7:0], r};
			m = dec(en);
			tick(2);
			rv = 1'b1;
			tick(1);
			rv = 1'b0;
			tick(1);
			chk(pend, 0);
			u_host.xfer(8'h40, 8, q);
			chk(q, 32'(m.code));
			u_host.xfer(8'h58, app ? 32 : 24, q);
			chk(q, app ? {rd, 4'h0, m.code} : {8'h0, rd});
			tick(2);
			chk(pend, 1);
		end
		// Write-enable bit high: both bytes (0xd8, then toggled 0xaa) must be ignored
		u_host.xfer(8'hd8, 8, q);
		u_host.xfer(8'h60, 8, q);
		chk(q, IDV);
		u_host.xfer(8'h20, 8, q);
		u_host.xfer(8'h60, 8, q);
		chk(q, IDV);
		final_report();
	end

	// Watchdog
	initial begin
		#300000;
		miscompares++;
		final_report();
	end
endmodule : test_adc_channel_select_result_readout
